// *** rtl/pec_error_counters.sv ***
// error counters, led routing, jabber carrier gate and crossover control
//
// Operation
// [R1] false carrier count, 16 bits, advances per false carrier event
// [R2] disconnect count advances by one per disconnect event
// [R3] error frame count advances at most once per errored frame
// [R4] symbol error count advances on symbol errors
// [R5] each run of six consecutive bad symbols counts once
// [R6] premature end of frame count advances per event
// [R7] slow receive end of frame error count advances per event
// [R8] slow transmit jabber count advances per event
// [R9] counters saturate at all ones and clear when read
// [R10] bit 3 gates carrier sense off during fast jabber; resets 0
// [R11] three bit code routes functions or fixed levels to two leds
// [R12] bit 7 enables automatic crossover resolution
// [R13] with auto off, bit 6 forces crossover or straight pairs
// [R14] bit 5 reports pair configuration in use
// [R15] bit 4 reports resolution complete
// [R16] bits 3:0 set slot time, 80 ms to 105 ms, reset 0
// [R17] master writes zero to crossover bits 15:8
// [R18] slot codes spaced evenly between endpoints in clock cycles
// [R19] event during clearing read counts after clear; reset zeroes
`timescale 1ns/1ps

module pec_error_counters
    import pec_pkg::*;
#(
    parameter int SLOT_BASE = SLOT_BASE_CYC,
    parameter int SLOT_STEP = SLOT_STEP_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [4:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // datapath events
    input wire pec_evt_t EVT,
    input wire logic FRAME_ACTIVE,
    input wire logic RX_ERR,
    input wire logic SYM_STROBE,
    input wire logic SYM_BAD,
    // carrier sense
    input wire logic CRS_IN,
    input wire logic JABBER_100,
    output logic CRS_OUT,
    // leds
    input wire logic LED_ACT,
    input wire logic LED_LINK,
    input wire logic LED_SPEED,
    input wire logic LED_COL,
    output logic ACTIVITY_LED_N,
    output logic LINK_LED_N,
    // crossover
    input wire logic LINK_GOOD,
    output logic MDIX_SEL,
    // interrupt
    output logic IRQ
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [15:0] cnt_reg [NUM_CNT];
    logic [NUM_CNT-1:0] inc;
    logic [NUM_CNT-1:0] clr;
    logic err_seen_reg;
    logic [2:0] run_reg;
    logic sym_hit;
    logic [15:0] lj_reg;
    logic [15:0] xo_reg;
    logic [6:0] status_reg;
    logic [6:0] mask_reg;
    logic [15:0] rd_next;
    logic [15:0] rdata_reg;
    pec_xo_state_t xo_state_reg;
    pec_xo_state_t xo_state_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] slot_lim;
    logic mdix_reg;
    logic [2:0] led_code;
    logic [1:0] led_on;

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------
    assign sym_hit = SYM_STROBE && SYM_BAD && run_reg == 3'h0;
    assign inc[CNT_FC] = EVT.false_carrier; // [R1]
    assign inc[CNT_DISC] = EVT.disconnect; // [R2]
    assign inc[CNT_EFRM] = RX_ERR && FRAME_ACTIVE && !err_seen_reg; // [R3]
    assign inc[CNT_SYM] = sym_hit; // [R4]
    assign inc[CNT_PEOF] = EVT.premature_eof; // [R6]
    assign inc[CNT_SEOF] = EVT.slow_eof_error; // [R7]
    assign inc[CNT_JAB] = EVT.jabber_10; // [R8]

    // one error-frame count per frame; the flag drops between frames
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            err_seen_reg <= 1'b0;
        end else if (!FRAME_ACTIVE) begin
            err_seen_reg <= 1'b0;
        end else if (RX_ERR) begin
            err_seen_reg <= 1'b1; // [R3]
        end
    end

    // bad symbol run: first of each group of six counts, good symbol restarts
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            run_reg <= 3'h0;
        end else if (SYM_STROBE) begin
            if (!SYM_BAD) begin
                run_reg <= 3'h0;
            end else if (run_reg == 3'(SYM_RUN_LEN - 1)) begin
                run_reg <= 3'h0; // [R5]
            end else begin
                run_reg <= run_reg + 3'h1; // [R5]
            end
        end
    end

    // ----------------------------------------------------------------
    // saturating clear-on-read counters
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            assign clr[gi] = REG_RD && REG_ADDR == REG_FALSE_CARRIER + 5'(gi);
            always_ff @(posedge CLK) begin
                if (!RESET_N) begin
                    cnt_reg[gi] <= CNT_RST; // [R19]
                end else if (clr[gi]) begin
                    // old value was captured for the read; keep the new event
                    cnt_reg[gi] <= {15'h0000, inc[gi]}; // [R9] [R19]
                end else if (inc[gi] && cnt_reg[gi] != CNT_FULL) begin
                    cnt_reg[gi] <= cnt_reg[gi] + 16'h0001; // [R9]
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            lj_reg <= LJ_RST;
        end else if (REG_WR && REG_ADDR == REG_LED_JABBER_CTRL) begin
            lj_reg <= REG_WDATA & LJ_WMASK; // [R10] [R11]
        end
    end

    // upper byte is not stored, so a stray write there cannot steer anything
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            xo_reg <= XO_RST;
        end else if (REG_WR && REG_ADDR == REG_CROSSOVER_CTRL) begin
            xo_reg <= REG_WDATA & XO_WMASK; // [R12] [R16] [R17]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mask_reg <= MASK_RST;
        end else if (REG_WR && REG_ADDR == REG_EVENT_MASK) begin
            mask_reg <= REG_WDATA[6:0];
        end
    end

    // sticky event status; a new event wins over the clearing read
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            status_reg <= 7'h00;
        end else if (REG_RD && REG_ADDR == REG_EVENT_STATUS) begin
            status_reg <= inc;
        end else begin
            status_reg <= status_reg | inc;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_reg & mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_next = 16'h0000;
        if (REG_ADDR >= REG_FALSE_CARRIER
            && REG_ADDR <= REG_JABBER_EVENT) begin
            rd_next = cnt_reg[3'(REG_ADDR - REG_FALSE_CARRIER)];
        end else if (REG_ADDR == REG_LED_JABBER_CTRL) begin
            rd_next = lj_reg;
        end else if (REG_ADDR == REG_CROSSOVER_CTRL) begin
            rd_next = xo_reg;
            rd_next[XO_STAT_BIT] = mdix_reg; // [R14]
            rd_next[XO_DONE_BIT] = xo_state_reg == XO_LOCKED; // [R15]
        end else if (REG_ADDR == REG_EVENT_STATUS) begin
            rd_next = {9'h000, status_reg};
        end else if (REG_ADDR == REG_EVENT_MASK) begin
            rd_next = {9'h000, mask_reg};
        end
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rdata_reg <= 16'h0000;
        end else if (REG_RD) begin
            rdata_reg <= rd_next;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end
    assign REG_RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // carrier sense gate and led routing
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CRS_OUT <= 1'b0;
        end else begin
            CRS_OUT <= CRS_IN
                && !(lj_reg[LJ_RXJAB_BIT] && JABBER_100); // [R10]
        end
    end

    assign led_code = lj_reg[LJ_LED_LSB +: 3];
    always_comb begin
        case (led_code) // [R11]
            LED_ACT_LINK: led_on = {LED_ACT, LED_LINK};
            LED_SPD_COL: led_on = {LED_SPEED, LED_COL};
            LED_SPD_LINK: led_on = {LED_SPEED, LED_LINK};
            LED_ACT_COL: led_on = {LED_ACT, LED_COL};
            LED_OFF_OFF: led_on = 2'h0;
            LED_OFF_ON: led_on = 2'h1;
            LED_ON_OFF: led_on = 2'h2;
            default: led_on = 2'h3;
        endcase
    end

    // leds are active low; off during reset
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ACTIVITY_LED_N <= 1'b1;
            LINK_LED_N <= 1'b1;
        end else begin
            ACTIVITY_LED_N <= !led_on[1];
            LINK_LED_N <= !led_on[0];
        end
    end

    // ----------------------------------------------------------------
    // crossover resolution
    // ----------------------------------------------------------------
    // truncated step keeps code 15 a little under 105 ms
    assign slot_lim = TMR_W'(SLOT_BASE)
        + TMR_W'(xo_reg[XO_TMR_LSB +: 4]) * TMR_W'(SLOT_STEP); // [R16] [R18]

    always_comb begin
        xo_state_next = xo_state_reg;
        case (xo_state_reg)
            XO_FORCED: begin
                if (xo_reg[XO_AUTO_BIT]) xo_state_next = XO_HUNT; // [R12]
            end
            XO_HUNT: begin
                if (!xo_reg[XO_AUTO_BIT]) xo_state_next = XO_FORCED;
                else if (LINK_GOOD) xo_state_next = XO_LOCKED; // [R15]
            end
            XO_LOCKED: begin
                if (!xo_reg[XO_AUTO_BIT]) xo_state_next = XO_FORCED;
                else if (!LINK_GOOD) xo_state_next = XO_HUNT;
            end
            default: xo_state_next = XO_FORCED;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            xo_state_reg <= XO_FORCED;
        end else begin
            xo_state_reg <= xo_state_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            tmr_reg <= '0;
            mdix_reg <= 1'b0;
        end else if (xo_state_reg != XO_HUNT || xo_state_next != XO_HUNT) begin
            tmr_reg <= '0;
            if (!xo_reg[XO_AUTO_BIT]) begin
                mdix_reg <= xo_reg[XO_MANUAL_BIT]; // [R13]
            end
        end else if (tmr_reg >= slot_lim - TMR_W'(1)) begin
            tmr_reg <= '0;
            mdix_reg <= !mdix_reg; // [R16]
        end else begin
            tmr_reg <= tmr_reg + TMR_W'(1);
        end
    end
    assign MDIX_SEL = mdix_reg; // [R14]

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_sat_hold: assert property ( // [R9]
        cnt_reg[CNT_DISC] == CNT_FULL && !clr[CNT_DISC]
        |=> cnt_reg[CNT_DISC] == CNT_FULL)
        else $error("disconnect count left saturation");
    a_read_clear: assert property ( // [R9]
        clr[CNT_JAB] && !inc[CNT_JAB] |=> cnt_reg[CNT_JAB] == 16'h0000)
        else $error("jabber count not cleared by read");
    a_read_keep_evt: assert property ( // [R19]
        clr[CNT_FC] && inc[CNT_FC] |=> cnt_reg[CNT_FC] == 16'h0001)
        else $error("event lost during clearing read");
    a_fc_step: assert property ( // [R1]
        inc[CNT_FC] && !clr[CNT_FC] && cnt_reg[CNT_FC] != CNT_FULL
        |=> cnt_reg[CNT_FC] == $past(cnt_reg[CNT_FC]) + 16'h0001)
        else $error("false carrier count did not advance");
    a_disc_step: assert property ( // [R2]
        !inc[CNT_DISC] && !clr[CNT_DISC]
        |=> $stable(cnt_reg[CNT_DISC]))
        else $error("disconnect count moved without event");
    a_frame_once: assert property ( // [R3]
        inc[CNT_EFRM] ##1 FRAME_ACTIVE [*2] |-> !inc[CNT_EFRM])
        else $error("error frame counted twice");
    a_sym_group: assert property ( // [R5]
        sym_hit ##1 (SYM_STROBE && SYM_BAD) [*5] |-> !sym_hit)
        else $error("bad symbol run counted more than once");
    a_crs_gate: assert property ( // [R10]
        lj_reg[LJ_RXJAB_BIT] && JABBER_100 |=> !CRS_OUT)
        else $error("carrier sense not gated in jabber");
    a_led_fixed: assert property ( // [R11]
        led_code == LED_OFF_ON |=> ACTIVITY_LED_N && !LINK_LED_N)
        else $error("fixed led code not obeyed");
    a_manual_pair: assert property ( // [R13]
        !xo_reg[XO_AUTO_BIT] ##1 !xo_reg[XO_AUTO_BIT]
        |-> MDIX_SEL == $past(xo_reg[XO_MANUAL_BIT]))
        else $error("manual pair selection not applied");
    a_ctrl_read: assert property ( // [R14]
        REG_RD && REG_ADDR == REG_CROSSOVER_CTRL
        |=> REG_RDATA[XO_STAT_BIT] == $past(mdix_reg))
        else $error("pair status read mismatch");

    c_sat: cover property (cnt_reg[CNT_DISC] == CNT_FULL);
    c_read_evt: cover property (clr[CNT_FC] && inc[CNT_FC]);
    c_lock: cover property (xo_state_reg == XO_HUNT
        ##1 xo_state_reg == XO_LOCKED);
    c_irq: cover property ($rose(IRQ));

endmodule

// *** common/pec_pkg.sv ***
// package: offsets, fields, resets, timing and types of the error counter block
package pec_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_FALSE_CARRIER = 5'h13;
    localparam logic [4:0] REG_DISCONNECT = 5'h14;
    localparam logic [4:0] REG_ERROR_FRAME = 5'h15;
    localparam logic [4:0] REG_SYMBOL_ERROR = 5'h16;
    localparam logic [4:0] REG_PREMATURE_EOF = 5'h17;
    localparam logic [4:0] REG_SLOW_EOF_ERROR = 5'h18;
    localparam logic [4:0] REG_JABBER_EVENT = 5'h19;
    localparam logic [4:0] REG_LED_JABBER_CTRL = 5'h1B;
    localparam logic [4:0] REG_CROSSOVER_CTRL = 5'h1C;
    localparam logic [4:0] REG_EVENT_STATUS = 5'h1D;
    localparam logic [4:0] REG_EVENT_MASK = 5'h1E;

    // ----------------------------------------------------------------
    // counter indices, base at the false carrier offset
    // ----------------------------------------------------------------
    localparam int NUM_CNT = 7;
    localparam int CNT_FC = 0;
    localparam int CNT_DISC = 1;
    localparam int CNT_EFRM = 2;
    localparam int CNT_SYM = 3;
    localparam int CNT_PEOF = 4;
    localparam int CNT_SEOF = 5;
    localparam int CNT_JAB = 6;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int LJ_PROBE_BIT = 5;
    localparam int LJ_RXJAB_BIT = 3;
    localparam int LJ_LED_LSB = 0;
    localparam logic [15:0] LJ_WMASK = 16'h002F;
    localparam logic [15:0] LJ_RST = 16'h0000;
    localparam int XO_AUTO_BIT = 7;
    localparam int XO_MANUAL_BIT = 6;
    localparam int XO_STAT_BIT = 5;
    localparam int XO_DONE_BIT = 4;
    localparam int XO_TMR_LSB = 0;
    localparam logic [15:0] XO_WMASK = 16'h00CF;
    localparam logic [15:0] XO_RST = 16'h0000;
    localparam logic [6:0] MASK_RST = 7'h00;

    // ----------------------------------------------------------------
    // led routing codes
    // ----------------------------------------------------------------
    localparam logic [2:0] LED_ACT_LINK = 3'h0;
    localparam logic [2:0] LED_SPD_COL = 3'h1;
    localparam logic [2:0] LED_SPD_LINK = 3'h2;
    localparam logic [2:0] LED_ACT_COL = 3'h3;
    localparam logic [2:0] LED_OFF_OFF = 3'h4;
    localparam logic [2:0] LED_OFF_ON = 3'h5;
    localparam logic [2:0] LED_ON_OFF = 3'h6;
    localparam logic [2:0] LED_ON_ON = 3'h7;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int SYM_RUN_LEN = 6;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SLOT_MIN_US = 80000;
    localparam int SLOT_MAX_US = 105000;
    localparam int SLOT_CODES = 15;
    localparam int SLOT_BASE_CYC = SLOT_MIN_US * (1000000 / CLK_PERIOD_PS);
    localparam int SLOT_STEP_CYC = (SLOT_MAX_US - SLOT_MIN_US)
        * (1000000 / CLK_PERIOD_PS) / SLOT_CODES;
    localparam int TMR_W = 25;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic false_carrier;
        logic disconnect;
        logic premature_eof;
        logic slow_eof_error;
        logic jabber_10;
    } pec_evt_t;

    typedef enum logic [1:0] {
        XO_FORCED = 2'b00,
        XO_HUNT = 2'b01,
        XO_LOCKED = 2'b10
    } pec_xo_state_t;

endpackage

// *** testbench/pec_mac_model.sv ***
// management master model that drives the register port
`timescale 1ns/1ps

module pec_mac_model
    import pec_pkg::*;
(
    // clock
    input wire logic CLK,
    // register port
    output logic [4:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD
);
    initial begin
        REG_ADDR = 5'h00;
        REG_WDATA = 16'h0000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        // reserved crossover bits always go out as zero
        REG_WDATA <= (a == REG_CROSSOVER_CTRL) ? (d & 16'h00FF) : d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        // a released bus shows the inverse, never a stale value
        REG_ADDR <= ~a;
        REG_WDATA <= ~d;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        REG_ADDR <= ~a;
    endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the error counter block
`timescale 1ns/1ps

module tb;
    import pec_pkg::*;
    typedef struct packed {
        logic [15:0] e;
        logic [15:0] m;
    } pec_note_t;
    localparam int SLOT_B = 20;
    localparam int SLOT_S = 2;
    logic CLK, RESET_N, REG_WR, REG_RD, rd_d;
    logic [4:0] REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA;
    pec_evt_t EVT;
    logic FRAME_ACTIVE, RX_ERR, SYM_STROBE, SYM_BAD, CRS_IN, JABBER_100;
    logic CRS_OUT, LED_ACT, LED_LINK, LED_SPEED, LED_COL;
    logic ACTIVITY_LED_N, LINK_LED_N, LINK_GOOD, MDIX_SEL, IRQ;
    int errors, num_checks, cyc, n, w;
    integer seed;
    pec_note_t exp_q[$];
    pec_note_t note;
    logic [4:0] offs [5];

    pec_mac_model mac_u (.CLK(CLK), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD));

    pec_error_counters #(.SLOT_BASE(SLOT_B), .SLOT_STEP(SLOT_S)) dut_u (
        .CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .EVT(EVT), .FRAME_ACTIVE(FRAME_ACTIVE),
        .RX_ERR(RX_ERR), .SYM_STROBE(SYM_STROBE), .SYM_BAD(SYM_BAD),
        .CRS_IN(CRS_IN), .JABBER_100(JABBER_100), .CRS_OUT(CRS_OUT),
        .LED_ACT(LED_ACT), .LED_LINK(LED_LINK), .LED_SPEED(LED_SPEED),
        .LED_COL(LED_COL), .ACTIVITY_LED_N(ACTIVITY_LED_N),
        .LINK_LED_N(LINK_LED_N), .LINK_GOOD(LINK_GOOD),
        .MDIX_SEL(MDIX_SEL), .IRQ(IRQ));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // the note goes in before the strobe, the monitor takes it off
    task automatic rd(input logic [4:0] a, input logic [15:0] e,
        input logic [15:0] m = 16'hFFFF);
        exp_q.push_back({e, m});
        mac_u.rd(a);
    endtask

    task automatic pulse(input int b, input int k);
        @(posedge CLK);
        EVT <= pec_evt_t'(5'h01 << b);
        repeat (k) @(posedge CLK);
        EVT <= '0;
    endtask

    task automatic wait_toggle(output int t);
        logic s;
        @(negedge CLK);
        s = MDIX_SEL;
        t = 1;
        while (MDIX_SEL === s && t < 200) begin
            @(negedge CLK);
            t++;
        end
    endtask

    function automatic logic led_f(input int c, input bit a);
        case (c)
            0: return a ? LED_ACT : LED_LINK;
            1: return a ? LED_SPEED : LED_COL;
            2: return a ? LED_SPEED : LED_LINK;
            3: return a ? LED_ACT : LED_COL;
            default: return a ? c[1] : c[0];
        endcase
    endfunction

    // ----------------------------------------------------------------
    // clock, watchdog and read monitor
    // ----------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    initial begin
        cyc = 0;
        forever begin
            @(posedge CLK);
            cyc++;
            if (cyc == 95000) begin
                errors++;
                wrap_up();
            end
        end
    end

    always @(posedge CLK) rd_d <= REG_RD;

    always @(negedge CLK) begin
        if (rd_d && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk("rdata", REG_RDATA & note.m, note.e & note.m);
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {errors, num_checks} = '0;
        seed = 39;
        RESET_N = 1'b0;
        EVT = '0;
        {FRAME_ACTIVE, RX_ERR, SYM_STROBE, SYM_BAD, CRS_IN} = '0;
        {JABBER_100, LED_ACT, LED_LINK, LED_SPEED, LED_COL} = '0;
        LINK_GOOD = 1'b0;
        offs = '{REG_FALSE_CARRIER, REG_DISCONNECT, REG_PREMATURE_EOF,
            REG_SLOW_EOF_ERROR, REG_JABBER_EVENT};
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(offs[i], 16'h0000);
        end
        rd(REG_LED_JABBER_CTRL, 16'h0000);
        rd(REG_CROSSOVER_CTRL, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            n = 1 + $unsigned($random(seed)) % 5;
            pulse(4 - i, n);
            rd(offs[i], 16'(n));
            rd(offs[i], 16'h0000);
        end
        fork
            rd(REG_FALSE_CARRIER, 16'h0000);
            pulse(4, 1);
        join
        rd(REG_FALSE_CARRIER, 16'h0001);
        // holding the pulse a full count plus a few proves the ceiling
        pulse(3, 65540);
        rd(REG_DISCONNECT, 16'hFFFF);
        rd(REG_DISCONNECT, 16'h0000);
        wr_and_read_back();
        $display("test counters done");
        rd(REG_EVENT_STATUS, 16'h0073, 16'h007F);
        mac_u.wr(REG_EVENT_MASK, 16'h0002);
        pulse(4, 1);
        repeat (3) @(negedge CLK);
        chk("irq masked", {15'h0, IRQ}, 16'h0000);
        pulse(3, 1);
        repeat (3) @(negedge CLK);
        chk("irq raised", {15'h0, IRQ}, 16'h0001);
        rd(REG_EVENT_STATUS, 16'h0003, 16'h007F);
        repeat (3) @(negedge CLK);
        chk("irq cleared", {15'h0, IRQ}, 16'h0000);
        rd(REG_FALSE_CARRIER, 16'h0001);
        rd(REG_DISCONNECT, 16'h0001);
        $display("test interrupt done");
        for (int f = 0; f < 2; f++) begin
            @(posedge CLK);
            FRAME_ACTIVE <= 1'b1;
            repeat (3 - f) begin
                @(posedge CLK);
                RX_ERR <= 1'b1;
                @(posedge CLK);
                RX_ERR <= 1'b0;
            end
            @(posedge CLK);
            FRAME_ACTIVE <= 1'b0;
        end
        rd(REG_ERROR_FRAME, 16'h0002);
        @(posedge CLK);
        {FRAME_ACTIVE, SYM_STROBE, SYM_BAD} <= 3'h7;
        repeat (13) @(posedge CLK);
        SYM_BAD <= 1'b0;
        @(posedge CLK);
        SYM_BAD <= 1'b1;
        @(posedge CLK);
        {FRAME_ACTIVE, SYM_STROBE, SYM_BAD} <= 3'h0;
        rd(REG_SYMBOL_ERROR, 16'h0004);
        $display("test frame errors done");
        for (int c = 0; c < 8; c++) begin
            mac_u.wr(REG_LED_JABBER_CTRL, 16'(c));
            {LED_ACT, LED_LINK, LED_SPEED, LED_COL} <= 4'($random(seed));
            repeat (3) @(negedge CLK);
            chk("act led", {15'h0, ACTIVITY_LED_N},
                {15'h0, ~led_f(c, 1'b1)});
            chk("link led", {15'h0, LINK_LED_N},
                {15'h0, ~led_f(c, 1'b0)});
        end
        @(posedge CLK);
        CRS_IN <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            mac_u.wr(REG_LED_JABBER_CTRL, (k < 2) ? 16'h0008 : 16'h0000);
            JABBER_100 <= (k != 1);
            repeat (3) @(negedge CLK);
            chk("crs", {15'h0, CRS_OUT}, {15'h0, k != 0});
        end
        $display("test leds and carrier done");
        mac_u.wr(REG_CROSSOVER_CTRL, 16'h0040);
        repeat (2) @(negedge CLK);
        chk("mdix forced", {15'h0, MDIX_SEL}, 16'h0001);
        rd(REG_CROSSOVER_CTRL, 16'h0060, 16'hFFEF);
        mac_u.wr(REG_CROSSOVER_CTRL, 16'h0000);
        repeat (2) @(negedge CLK);
        chk("mdi forced", {15'h0, MDIX_SEL}, 16'h0000);
        rd(REG_CROSSOVER_CTRL, 16'h0000, 16'hFFEF);
        // manual bit is set again here; with auto on only the auto path can make a toggle
        mac_u.wr(REG_CROSSOVER_CTRL, 16'h00C3);
        wait_toggle(w);
        wait_toggle(w);
        chk("slot", 16'(w), 16'(SLOT_B + 3 * SLOT_S));
        @(posedge CLK);
        LINK_GOOD <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(REG_CROSSOVER_CTRL, 16'h00D3, 16'h00DF);
        $display("test crossover done");
        repeat (4) @(posedge CLK);
        wrap_up();
    end

    task automatic wr_and_read_back();
        mac_u.wr(REG_LED_JABBER_CTRL, 16'hFFFF);
        rd(REG_LED_JABBER_CTRL, 16'h002F);
        mac_u.wr(REG_FALSE_CARRIER, 16'h1234);
        rd(REG_FALSE_CARRIER, 16'h0000);
        rd(5'h1A, 16'h0000);
        rd(5'h00, 16'h0000);
    endtask
endmodule
